// file: verilog/serial_pkg.sv
// Package for the asynchronous serial transmitter/receiver core.
// Assumes a single 250 MHz clock and a plain register port with 8-bit data.
package serial_pkg;
   // Register offsets.
   localparam logic [2:0] OFF_CTRL_ONE = 3'h0;
   localparam logic [2:0] OFF_CTRL_TWO = 3'h1;
   localparam logic [2:0] OFF_STATUS_ONE = 3'h2;
   localparam logic [2:0] OFF_DATA_HIGH = 3'h3;
   localparam logic [2:0] OFF_DATA_LOW = 3'h4;
   localparam logic [2:0] OFF_BAUD_LOW = 3'h5;
   localparam logic [2:0] OFF_BAUD_HIGH = 3'h6;
   // Control one field positions.
   localparam int BIT_PARITY_ODD = 0;
   localparam int BIT_PARITY_ON = 1;
   localparam int BIT_IDLE_START = 2;
   localparam int BIT_NINE_BITS = 4;
   localparam int BIT_RX_SOURCE = 5;
   localparam int BIT_LOOPBACK = 7;
   // Control two field positions.
   localparam int BIT_SEND_BREAK = 0;
   localparam int BIT_RX_ENABLE = 2;
   localparam int BIT_TX_ENABLE = 3;
   localparam int BIT_IDLE_IRQ_EN = 4;
   localparam int BIT_RX_IRQ_EN = 5;
   localparam int BIT_DONE_IRQ_EN = 6;
   localparam int BIT_EMPTY_IRQ_EN = 7;
   // Status one field positions.
   localparam int BIT_PARITY_ERR = 0;
   localparam int BIT_FRAME_ERR = 1;
   localparam int BIT_NOISE = 2;
   localparam int BIT_OVERRUN = 3;
   localparam int BIT_IDLE = 4;
   localparam int BIT_RX_FULL = 5;
   localparam int BIT_TX_DONE = 6;
   localparam int BIT_TX_EMPTY = 7;
   // Reset values.
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [12:0] RST_BAUD = 13'h0004;
   // Oversampling figures.
   localparam logic [3:0] OVERSAMPLE = 4'hF;
   localparam logic [3:0] TICK_3 = 4'h3;
   localparam logic [3:0] TICK_5 = 4'h5;
   localparam logic [3:0] TICK_7 = 4'h7;
   localparam logic [3:0] TICK_8 = 4'h8;
   localparam logic [3:0] TICK_9 = 4'h9;
   localparam logic [3:0] TICK_10 = 4'hA;
   localparam logic [3:0] IDLE_BITS_EIGHT = 4'hA;
   localparam logic [3:0] IDLE_BITS_NINE = 4'hB;
   typedef enum logic [2:0] {
      RX_SEARCH = 3'b001,
      RX_START = 3'b010,
      RX_DATA = 3'b100
   } rx_state_t;
endpackage : serial_pkg

// file: verilog/async_serial_rx_tx_core.sv
// Asynchronous serial transmitter/receiver with 16x oversampled receiver.
// Assumes rx_pin is asynchronous; registers are reached over a plain strobe port.
// Notes on behaviour
// - Idle count starts after start or stop.
// - Parity occupies the data field's top bit.
// - Odd select inverts the even parity bit.
// - Loopback and single-wire routing of receiver input.
// - Receiver times bits with sixteen-times clock.
// - Resync after start and one-to-zero data change.
// - Start is zero after three ones.
// - Ticks three, five, seven verify start.
// - Failed verification restarts the start search.
// - Enabled sources ORed onto one request.
// - Empty sets on load; status read, write clears.
// - Done sets when idle; pin idles high except in single-wire mode.
// - Break has no stop bit, then done.
// - Done clears by sequence or new queueing.
// - Full sets on transfer; status read, read clears.
// - Receive interrupt enable makes full raise request.
// - Overrun drops new frame, keeps held data.
// - Idle after ten or eleven ones.
// - Idle rearms only after full sets.
`timescale 1ns/1ps
`default_nettype none
module async_serial_rx_tx_core
   import serial_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [2:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic rx_pin,
   output logic tx_out,
   output logic tx_oe,
   output logic irq
);
   import serial_pkg::*;

   logic [7:0] serial_control_one;
   logic [7:0] serial_control_two;
   logic [12:0] baud_div;
   logic [12:0] baud_cnt;
   logic tick;
   logic rx_s1, rx_s2;
   logic rx_in;
   logic tx_line;
   logic tx_empty_flag, tx_done_flag, rx_full_flag, overrun, idle_flag;
   logic noise, frame_err, parity_err;
   logic idle_armed;
   logic status_seen;
   logic [8:0] tx_hold;
   logic tx_hold_brk;
   logic [10:0] tx_shift;
   logic [3:0] tx_bits;
   logic [3:0] tx_tick;
   logic tx_busy;
   logic [8:0] rx_data;
   rx_state_t rx_state;
   logic [3:0] oversample_clock;
   logic [2:0] ones_hist;
   logic [2:0] smp;
   logic [3:0] rx_bitn;
   logic [9:0] rx_shift;
   logic prev_bit;
   logic [3:0] edge_pos;
   logic [3:0] idle_cnt;
   logic [3:0] bit_tick;
   logic rx_done;

   wire nine = serial_control_one[BIT_NINE_BITS];
   wire par_on = serial_control_one[BIT_PARITY_ON];
   wire par_odd = serial_control_one[BIT_PARITY_ODD];
   wire [3:0] frame_bits = nine ? 4'hB : 4'hA;
   wire maj = (smp[0] & smp[1]) | (smp[0] & smp[2]) | (smp[1] & smp[2]);
   wire start_fail = (smp[0] & smp[1]) | (smp[0] & rx_in) | (smp[1] & rx_in);
   wire status_rd = rd && addr == OFF_STATUS_ONE;
   wire low_rd = rd && addr == OFF_DATA_LOW;
   wire low_wr = wr && addr == OFF_DATA_LOW;

   ////////////////////////////////////////////////////////////////////////////
   // Baud divider gives one enable pulse per oversample tick.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         baud_cnt <= 13'h0000;
         tick <= 1'b0;
      end else if (baud_cnt >= baud_div) begin
         baud_cnt <= 13'h0000;
         tick <= 1'b1;
      end else begin
         baud_cnt <= baud_cnt + 13'h0001;
         tick <= 1'b0;
      end
   end

   // Two-flop synchroniser for the receive pin.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rx_s1 <= 1'b1;
         rx_s2 <= 1'b1;
      end else begin
         rx_s1 <= rx_pin;
         rx_s2 <= rx_s1;
      end
   end

   // Receiver source routing; single-wire reads back the driven line.
   always_comb begin
      if (!serial_control_one[BIT_LOOPBACK]) begin
         rx_in = rx_s2;
      end else if (!serial_control_one[BIT_RX_SOURCE]) begin
         rx_in = tx_line;
      end else begin
         rx_in = tx_out;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control registers and baud divisor.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         serial_control_one <= RST_CTRL;
         serial_control_two <= RST_CTRL;
         baud_div <= RST_BAUD;
      end else if (wr) begin
         if (addr == OFF_CTRL_ONE) begin
            serial_control_one <= wdata;
         end else if (addr == OFF_CTRL_TWO) begin
            serial_control_two <= wdata;
         end else if (addr == OFF_BAUD_LOW) begin
            baud_div[7:0] <= wdata;
         end else if (addr == OFF_BAUD_HIGH) begin
            baud_div[12:8] <= wdata[4:0];
         end
      end
   end

   // Arms the clear sequence once status is read; a data-low read or write ends it.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         status_seen <= 1'b0;
      end else if (status_rd) begin
         status_seen <= 1'b1;
      end else if (low_rd || low_wr) begin
         status_seen <= 1'b0;
      end
   end

   // Read data stands in the cycle after the read strobe.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata <= 8'h00;
      end else if (rd) begin
         if (addr == OFF_CTRL_ONE) begin
            rdata <= serial_control_one;
         end else if (addr == OFF_CTRL_TWO) begin
            rdata <= serial_control_two;
         end else if (addr == OFF_STATUS_ONE) begin
            rdata <= {tx_empty_flag, tx_done_flag, rx_full_flag, idle_flag,
                      overrun, noise, frame_err, parity_err};
         end else if (addr == OFF_DATA_HIGH) begin
            rdata <= {rx_data[8], 7'h00};
         end else if (addr == OFF_DATA_LOW) begin
            rdata <= rx_data[7:0];
         end else if (addr == OFF_BAUD_LOW) begin
            rdata <= baud_div[7:0];
         end else if (addr == OFF_BAUD_HIGH) begin
            rdata <= {3'h0, baud_div[12:8]};
         end else begin
            rdata <= 8'h00;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transmit holding register; the ninth bit comes from a data-high write.
   wire tx_load = !tx_busy && !tx_empty_flag && tick;
   wire brk_req = serial_control_two[BIT_SEND_BREAK] && !tx_busy && tick && tx_empty_flag;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tx_hold <= 9'h000;
      end else if (wr && addr == OFF_DATA_HIGH) begin
         tx_hold[8] <= wdata[6];
      end else if (low_wr) begin
         tx_hold[7:0] <= wdata;
      end
   end

   // Even parity over the data below the top bit; odd select inverts it.
   function automatic logic [10:0] build_frame(input logic [8:0] d, input logic n,
                                               input logic pon, input logic podd);
      logic [8:0] f;
      logic p;
      f = d;
      p = 1'b0;
      if (n) begin
         p = ^d[7:0] ^ podd;
         if (pon) f[8] = p;
         build_frame = {1'b1, f, 1'b0};
      end else begin
         p = ^d[6:0] ^ podd;
         if (pon) f[7] = p;
         build_frame = {2'b11, f[7:0], 1'b0};
      end
   endfunction

   // Transmit shifter: one bit per sixteen ticks, start bit first.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tx_shift <= 11'h7FF;
         tx_bits <= 4'h0;
         tx_tick <= 4'h0;
         tx_busy <= 1'b0;
         tx_line <= 1'b1;
         tx_hold_brk <= 1'b0;
      end else if (tx_load && serial_control_two[BIT_TX_ENABLE]) begin
         tx_shift <= build_frame(tx_hold, nine, par_on, par_odd);
         tx_bits <= frame_bits;
         tx_tick <= 4'h0;
         tx_busy <= 1'b1;
         tx_hold_brk <= 1'b0;
      end else if (brk_req && serial_control_two[BIT_TX_ENABLE]) begin
         tx_shift <= 11'h000;
         tx_bits <= frame_bits;
         tx_tick <= 4'h0;
         tx_busy <= 1'b1;
         tx_hold_brk <= 1'b1;
      end else if (tx_busy && tick) begin
         tx_line <= tx_shift[0];
         tx_tick <= tx_tick + 4'h1;
         if (tx_tick == OVERSAMPLE) begin
            tx_shift <= {1'b1, tx_shift[10:1]};
            tx_bits <= tx_bits - 4'h1;
            if (tx_bits == 4'h1) begin
               tx_busy <= 1'b0;
            end
         end
      end else if (!tx_busy) begin
         tx_line <= 1'b1;
      end
   end

   // Pin output; the pin is released in loopback mode, and in single-wire mode it echoes the pin input while idle.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tx_out <= 1'b1;
         tx_oe <= 1'b0;
      end else begin
         tx_out <= serial_control_one[BIT_LOOPBACK] && serial_control_one[BIT_RX_SOURCE]
                   && !tx_busy ? rx_s2 : tx_line;
         tx_oe <= serial_control_two[BIT_TX_ENABLE]
                  && !(serial_control_one[BIT_LOOPBACK] && !serial_control_one[BIT_RX_SOURCE]);
      end
   end

   // Transmit flags; for empty the hardware set wins over the software clear, for done the clear wins.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tx_empty_flag <= 1'b1;
         tx_done_flag <= 1'b1;
      end else begin
         if (tx_load && serial_control_two[BIT_TX_ENABLE]) begin
            tx_empty_flag <= 1'b1;
         end else if (low_wr && status_seen && tx_empty_flag) begin
            tx_empty_flag <= 1'b0;
         end
         // Queueing a byte must drop done at once, not at the next baud tick.
         if (!tx_busy && tx_empty_flag && !brk_req && !(low_wr && status_seen)) begin
            tx_done_flag <= 1'b1;
         end else if ((low_wr && status_seen) || tx_load || brk_req) begin
            tx_done_flag <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receiver: start search, verification and majority data sampling.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rx_state <= RX_SEARCH;
         oversample_clock <= 4'h0;
         ones_hist <= 3'h0;
         smp <= 3'h7;
         rx_bitn <= 4'h0;
         rx_shift <= 10'h000;
         prev_bit <= 1'b1;
         edge_pos <= 4'h0;
         rx_done <= 1'b0;
         noise <= 1'b0;
      end else begin
         rx_done <= 1'b0;
         if (status_seen && low_rd) noise <= 1'b0;
         if (tick && serial_control_two[BIT_RX_ENABLE]) begin
            case (rx_state)
               RX_SEARCH: begin
                  ones_hist <= {ones_hist[1:0], rx_in};
                  if (!rx_in && ones_hist == 3'h7) begin
                     rx_state <= RX_START;
                     oversample_clock <= 4'h1;
                  end
               end
               RX_START: begin
                  oversample_clock <= oversample_clock + 4'h1;
                  if (oversample_clock == TICK_3) smp[0] <= rx_in;
                  if (oversample_clock == TICK_5) smp[1] <= rx_in;
                  if (oversample_clock == TICK_7) begin
                     // A verified start with any disagreeing sample is noisy.
                     if (!start_fail && (smp[0] | smp[1] | rx_in)) noise <= 1'b1;
                     if (start_fail) begin
                        rx_state <= RX_SEARCH;
                        oversample_clock <= 4'h0;
                        ones_hist <= 3'h0;
                     end
                  end
                  if (oversample_clock == OVERSAMPLE) begin
                     rx_state <= RX_DATA;
                     rx_bitn <= 4'h0;
                     prev_bit <= 1'b0;
                     oversample_clock <= 4'h0;
                  end
               end
               RX_DATA: begin
                  oversample_clock <= oversample_clock + 4'h1;
                  // Remember where the last falling edge fell, for the resync below.
                  ones_hist <= {ones_hist[1:0], rx_in};
                  if (ones_hist[0] && !rx_in) edge_pos <= oversample_clock;
                  if (oversample_clock == TICK_8) smp[0] <= rx_in;
                  if (oversample_clock == TICK_9) smp[1] <= rx_in;
                  if (oversample_clock == TICK_10) smp[2] <= rx_in;
                  if (oversample_clock == TICK_10 + 4'h1) begin
                     rx_shift <= {maj, rx_shift[9:1]};
                     prev_bit <= maj;
                     rx_bitn <= rx_bitn + 4'h1;
                     if ((smp[0] ^ smp[1]) | (smp[1] ^ smp[2])) noise <= 1'b1;
                     if (prev_bit && !maj) begin
                        oversample_clock <= TICK_10 + 4'h2 - edge_pos;
                     end
                     if (rx_bitn == frame_bits - 4'h2) begin
                        rx_done <= 1'b1;
                        rx_state <= RX_SEARCH;
                        ones_hist <= 3'h0;
                     end
                  end
               end
               default: rx_state <= RX_SEARCH;
            endcase
         end
      end
   end

   // Frame transfer into the data register, overrun and error flags.
   // The stop bit is the last one shifted in, so it sits at the top.
   wire stop_bit = rx_shift[9];
   wire [8:0] got = nine ? rx_shift[8:0] : {1'b0, rx_shift[8:1]};
   wire got_par = nine ? (^got[7:0] ^ par_odd) != got[8] : (^got[6:0] ^ par_odd) != got[7];
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rx_full_flag <= 1'b0;
         overrun <= 1'b0;
         rx_data <= 9'h000;
         frame_err <= 1'b0;
         parity_err <= 1'b0;
      end else begin
         if (rx_done && rx_full_flag) begin
            overrun <= 1'b1;
         end else if (rx_done) begin
            rx_full_flag <= 1'b1;
            rx_data <= got;
            frame_err <= !stop_bit;
            parity_err <= par_on && got_par;
         end else if (status_seen && low_rd) begin
            rx_full_flag <= 1'b0;
            overrun <= 1'b0;
            frame_err <= 1'b0;
            parity_err <= 1'b0;
         end
      end
   end

   // Idle detector counts one bit of ones per sixteen ticks of high line.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         idle_cnt <= 4'h0;
         bit_tick <= 4'h0;
         idle_flag <= 1'b0;
         idle_armed <= 1'b1;
      end else begin
         if (rx_done && !rx_full_flag) idle_armed <= 1'b1;
         if (tick) bit_tick <= bit_tick + 4'h1;
         if (!rx_in || (rx_state != RX_SEARCH && serial_control_one[BIT_IDLE_START])) begin
            idle_cnt <= 4'h0;
            bit_tick <= 4'h0;
         end else if (tick && bit_tick == OVERSAMPLE && idle_cnt != 4'hF) begin
            idle_cnt <= idle_cnt + 4'h1;
         end
         if (idle_armed && idle_cnt == (nine ? IDLE_BITS_NINE : IDLE_BITS_EIGHT)) begin
            idle_flag <= 1'b1;
            idle_armed <= 1'b0;
         end else if (status_seen && low_rd && idle_flag) begin
            idle_flag <= 1'b0;
         end
      end
   end

   // Single ORed request line.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq <= 1'b0;
      end else begin
         irq <= (tx_empty_flag & serial_control_two[BIT_EMPTY_IRQ_EN])
              | (tx_done_flag & serial_control_two[BIT_DONE_IRQ_EN])
              | ((rx_full_flag | overrun) & serial_control_two[BIT_RX_IRQ_EN])
              | (idle_flag & serial_control_two[BIT_IDLE_IRQ_EN]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   property p_full_irq;
      @(posedge clk) disable iff (!rstn)
         rx_full_flag && serial_control_two[BIT_RX_IRQ_EN] |=> irq;
   endproperty
   a_full_irq: assert property (p_full_irq) else $error("full flag without request");

   property p_overrun_keeps;
      @(posedge clk) disable iff (!rstn)
         rx_done && rx_full_flag |=> overrun && $stable(rx_data);
   endproperty
   a_overrun_keeps: assert property (p_overrun_keeps) else $error("overrun lost data");

   property p_done_idle_high;
      @(posedge clk) disable iff (!rstn)
         tx_done_flag && !tx_busy |=> tx_line;
   endproperty
   a_done_idle_high: assert property (p_done_idle_high) else $error("line low while done");

   // A start whose samples are mostly high sends the receiver back to search.
   sequence s_start_reject;
      tick && serial_control_two[BIT_RX_ENABLE] && rx_state == RX_START
         && oversample_clock == TICK_7 && start_fail;
   endsequence
   property p_start_reject;
      @(posedge clk) disable iff (!rstn)
         s_start_reject |=> rx_state == RX_SEARCH && oversample_clock == 4'h0;
   endproperty
   a_start_reject: assert property (p_start_reject) else $error("bad start kept");

   property p_empty_on_load;
      @(posedge clk) disable iff (!rstn)
         tx_load && serial_control_two[BIT_TX_ENABLE] |=> tx_empty_flag && tx_busy;
   endproperty
   a_empty_on_load: assert property (p_empty_on_load) else $error("empty not set");

   property p_loop_released;
      @(posedge clk) disable iff (!rstn)
         serial_control_one[BIT_LOOPBACK] && !serial_control_one[BIT_RX_SOURCE] |=> !tx_oe;
   endproperty
   a_loop_released: assert property (p_loop_released) else $error("pin driven in loop");
endmodule : async_serial_rx_tx_core
`default_nettype wire

// file: tb/remote_serial.sv
// Remote asynchronous transceiver that faces the core's serial pins.
// Assumes both ends use the same bit time and that the line idles high.
`timescale 1ns/1ps
`default_nettype none
module remote_serial #(
   parameter int BIT_CLKS = 80
) (
   input wire logic clk,
   input wire logic line_in,
   output logic line_out,
   output logic rx_busy,
   output logic [8:0] rx_word
);
   ////////////////////////////////////////////////////////////
   // Sends a start bit, nbits data bits low bit first, then one stop bit.
   task automatic send(input logic [8:0] w, input int nbits);
      int i;
      @(posedge clk);
      line_out <= 1'b0;
      repeat (BIT_CLKS) @(posedge clk);
      for (i = 0; i < nbits; i++) begin
         line_out <= w[i];
         repeat (BIT_CLKS) @(posedge clk);
      end
      line_out <= 1'b1;
      repeat (BIT_CLKS) @(posedge clk);
   endtask : send

   // A low pulse shorter than the start verification window.
   task automatic glitch(input int n);
      @(posedge clk);
      line_out <= 1'b0;
      repeat (n) @(posedge clk);
      line_out <= 1'b1;
   endtask : glitch

   ////////////////////////////////////////////////////////////
   // Samples mid-bit; the ninth sample is the stop bit of an eight-bit frame.
   initial begin : capture
      int i;
      line_out = 1'b1;
      rx_busy = 1'b0;
      rx_word = '0;
      forever begin
         @(posedge clk);
         if (line_in === 1'b0) begin
            rx_busy <= 1'b1;
            repeat (BIT_CLKS / 2) @(posedge clk);
            for (i = 0; i < 9; i++) begin
               repeat (BIT_CLKS) @(posedge clk);
               rx_word[i] <= line_in;
            end
            rx_busy <= 1'b0;
            // A break holds the line low, so wait for it to rise again.
            while (line_in !== 1'b1) @(posedge clk);
         end
      end
   end
endmodule : remote_serial
`default_nettype wire

// file: tb/async_serial_rx_tx_core_bench.sv
// Self-checking bench for the serial core: register tasks and a remote partner.
// Assumes the reset baud divisor, so one bit lasts 16 ticks of 5 clocks.
`timescale 1ns/1ps
`default_nettype none
module async_serial_rx_tx_core_bench;
   import serial_pkg::*;
   localparam int BIT = 80;
   logic clk, rstn, wr, rd, rx_pin, tx_out, tx_oe, irq, busy, line;
   logic [2:0] addr;
   logic [7:0] wdata, rdata, st, d;
   logic [8:0] word;
   int compares, miscompares, i;

   // A released transmit pin is pulled up, as an idle serial line would be.
   assign line = tx_oe ? tx_out : 1'b1;

   async_serial_rx_tx_core dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .rx_pin(rx_pin), .tx_out(tx_out),
      .tx_oe(tx_oe), .irq(irq));
   remote_serial #(.BIT_CLKS(BIT)) far (.clk(clk), .line_in(line), .line_out(rx_pin),
      .rx_busy(busy), .rx_word(word));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////
   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   // Read data stand from the cycle after the strobe until the next read, so sample there.
   task automatic rd_reg(input logic [2:0] a, output logic [7:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask : rd_reg

   task automatic wait_on(ref logic s, input logic v);
      int n;
      for (n = 0; n < 3000 && s !== v; n++) @(posedge clk);
      if (n == 3000) begin
         miscompares++;
         print_verdict();
      end
   endtask : wait_on

   // Queues a byte and checks the frame that the partner captured.
   task automatic tx_byte(input logic [7:0] v, input logic [8:0] exp);
      rd_reg(OFF_STATUS_ONE, st);
      wr_reg(OFF_DATA_LOW, v);
      rd_reg(OFF_STATUS_ONE, st);
      check(st[BIT_TX_DONE], 1'b0);
      wait_on(busy, 1'b1);
      wait_on(busy, 1'b0);
      check(word, exp);
      repeat (BIT) @(posedge clk);
      rd_reg(OFF_STATUS_ONE, st);
      check(st[BIT_TX_DONE], 1'b1);
      check(tx_out, 1'b1);
   endtask : tx_byte

   task automatic print_verdict();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : print_verdict

   ////////////////////////////////////////////////////////////
   // Main sequence: reset values, transmit, break, receive, flags, loopback.
   initial begin
      rstn = 1'b0;
      addr = '0;
      wdata = '0;
      wr = 1'b0;
      rd = 1'b0;
      compares = 0;
      miscompares = 0;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      #1 check({tx_out, tx_oe, irq}, 3'b100);
      rd_reg(OFF_CTRL_ONE, st);
      check(st, RST_CTRL);
      rd_reg(OFF_STATUS_ONE, st);
      check(st, 8'hC0);
      rd_reg(3'h7, st);
      check(st, 8'h00);
      wr_reg(OFF_CTRL_TWO, 8'h2C);
      // Both parity senses with an odd and an even count of ones.
      for (i = 0; i < 4; i++) begin
         d = i[1] ? 8'h01 : 8'h03;
         wr_reg(OFF_CTRL_ONE, {6'h00, 1'b1, i[0]});
         tx_byte(d, {1'b1, i[1] ^ i[0], d[6:0]});
      end
      wr_reg(OFF_CTRL_ONE, RST_CTRL);
      // Break is dropped once it starts, so exactly one goes out.
      wr_reg(OFF_CTRL_TWO, 8'h2D);
      wait_on(busy, 1'b1);
      wr_reg(OFF_CTRL_TWO, 8'h2C);
      wait_on(busy, 1'b0);
      check(word, 9'h000);
      repeat (2 * BIT) @(posedge clk);
      rd_reg(OFF_STATUS_ONE, st);
      check(st[BIT_TX_DONE], 1'b1);
      far.send(9'h0A5, 8);
      wait_on(irq, 1'b1);
      rd_reg(OFF_STATUS_ONE, st);
      // The long quiet line since reset has already raised idle.
      check(st & 8'h3C, 8'h30);
      rd_reg(OFF_DATA_LOW, st);
      check(st, 8'hA5);
      rd_reg(OFF_STATUS_ONE, st);
      check({st[BIT_RX_FULL], irq}, 2'b00);
      // Second frame arrives before the first is read.
      far.send(9'h011, 8);
      far.send(9'h022, 8);
      rd_reg(OFF_STATUS_ONE, st);
      check(st & 8'h28, 8'h28);
      rd_reg(OFF_DATA_LOW, st);
      check(st, 8'h11);
      rd_reg(OFF_STATUS_ONE, st);
      check(st & 8'h28, 8'h00);
      repeat (12 * BIT) @(posedge clk);
      rd_reg(OFF_STATUS_ONE, st);
      check(st[BIT_IDLE], 1'b1);
      rd_reg(OFF_DATA_LOW, st);
      repeat (12 * BIT) @(posedge clk);
      rd_reg(OFF_STATUS_ONE, st);
      check(st[BIT_IDLE], 1'b0);
      // A short glitch must be rejected and the search must restart.
      far.glitch(8);
      repeat (BIT) @(posedge clk);
      far.send(9'h05A, 8);
      rd_reg(OFF_STATUS_ONE, st);
      check(st & 8'h2C, 8'h20);
      rd_reg(OFF_DATA_LOW, st);
      check(st, 8'h5A);
      wr_reg(OFF_CTRL_ONE, 8'h80);
      rd_reg(OFF_STATUS_ONE, st);
      check(tx_oe, 1'b0);
      wr_reg(OFF_DATA_LOW, 8'h3C);
      wait_on(irq, 1'b1);
      rd_reg(OFF_STATUS_ONE, st);
      rd_reg(OFF_DATA_LOW, st);
      check(st, 8'h3C);
      print_verdict();
   end
endmodule : async_serial_rx_tx_core_bench
`default_nettype wire
